// ### src/pmc_pkg.sv
package pmc_pkg;
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP,
    MODE_RETAIN
  } mode_t;

  localparam int unsigned FLASH_BANKS = 2;
  localparam int unsigned SRAM_BANKS = 2;
  localparam int unsigned REG_COUNT = 4;
  localparam int unsigned FLASH_GOOD_NS = 2000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned FLASH_GOOD_CYC = (FLASH_GOOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] FLASH_SEL_RESET = 2'h3;
  localparam logic [1:0] SRAM_KEEP_RESET = 2'h3;
endpackage

// ### src/pmc_flash_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pmc_flash_if;
  logic request;
  logic [pmc_pkg::FLASH_BANKS-1:0] bank_sel;
  logic good;
  logic [pmc_pkg::FLASH_BANKS-1:0] bank_pwr;
  modport ctrl (output request, output bank_sel, input good, input bank_pwr);
  modport seq (input request, input bank_sel, output good, output bank_pwr);
endinterface
`default_nettype wire

// ### src/pmc_flash_seq.sv
`timescale 1ns/1ns
`default_nettype none
module pmc_flash_seq #(
  parameter int unsigned GOOD_CYC = pmc_pkg::FLASH_GOOD_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_flash_ready,
  pmc_flash_if.seq fl
);
  logic [15:0] cnt_q;
  logic [pmc_pkg::FLASH_BANKS-1:0] pwr_q;

  // Only selected banks power up
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pwr_q <= '0;
    end else if (fl.request) begin
      pwr_q <= fl.bank_sel;
    end else begin
      pwr_q <= '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= 16'h0000;
    end else if (!fl.request) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q < 16'(GOOD_CYC)) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Good only after settle time and the flash itself reports ready
  assign fl.good = fl.request && (cnt_q >= 16'(GOOD_CYC)) && i_flash_ready;
  assign fl.bank_pwr = pwr_q;
endmodule
`default_nettype wire

// ### src/power_mode_controller.sv
// Summary of operation
// - Four modes selectable by software: run, sleep, deep sleep, retention.
// - Run keeps all domains powered, oscillators running, processor clocked.
// - Sleep equals run but processor clock is gated.
// - Interrupt in sleep ungates clock and returns to run.
// - Deep sleep is sleep plus flash powered down.
// - Interrupt in deep sleep powers flash first, then resumes run.
// - SRAM banks and fast clock on except retention; there banks programmable.
// - Retention mode powers only retention registers and kept SRAM banks; contents preserved.
// - Retention: fast oscillators off, slow oscillator clocks gated processor.
// - Interrupt in retention powers flash and digital logic, then resumes.
// - Processor stalls after wake until flash is fully powered.
// - Flash banks powered on wake follow software bank settings.
// - Internal linear regulators follow current mode automatically.
// - After reset linear pre-regulator selected, switcher off until enabled.
// - Supplies tied at 1 V force 1 V mode, pre-regulator disabled.
// - Debugger attached with its enable pin up inhibits retention-mode entry.
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller #(
  parameter int unsigned GOOD_CYC = pmc_pkg::FLASH_GOOD_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_mode_sel,
  input wire logic i_mode_wr,
  input wire logic [pmc_pkg::SRAM_BANKS-1:0] i_sram_keep,
  input wire logic [pmc_pkg::FLASH_BANKS-1:0] i_flash_sel,
  input wire logic i_flash_sel_wr,
  input wire logic i_switcher_en,
  input wire logic i_switcher_wr,
  input wire logic i_wfi,
  input wire logic i_irq,
  input wire logic i_flash_ready,
  input wire logic i_low_volt_detect,
  input wire logic i_debug_enable_pin,
  input wire logic i_debug_attached,
  output logic [1:0] o_mode,
  output logic o_cpu_clk_en,
  output logic o_cpu_stall,
  output logic o_slow_clk_sel,
  output logic o_fast_osc_en,
  output logic o_digital_pwr,
  output logic [pmc_pkg::FLASH_BANKS-1:0] o_flash_pwr,
  output logic [pmc_pkg::SRAM_BANKS-1:0] o_sram_pwr,
  output logic o_retention_pwr,
  output logic o_prereg_en,
  output logic o_switcher_en,
  output logic o_one_volt_mode,
  output logic [pmc_pkg::REG_COUNT-1:0] o_ldo_en
);
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_DEEP,
    ST_RETAIN,
    ST_WAKE
  } state_t;

  state_t state_q;
  pmc_pkg::mode_t req_q;
  logic [pmc_pkg::FLASH_BANKS-1:0] fsel_q;
  logic [pmc_pkg::SRAM_BANKS-1:0] keep_q;
  logic sw_q;
  logic lv_q;
  logic dbg_ok;
  logic flash_req;
  pmc_flash_if fl ();

  pmc_flash_seq #(.GOOD_CYC(GOOD_CYC)) u_seq (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_flash_ready(i_flash_ready),
    .fl(fl)
  );

  // Debug only counts when its enable pin is up
  assign dbg_ok = i_debug_attached && i_debug_enable_pin;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      req_q <= pmc_pkg::MODE_RUN;
    end else if (i_mode_wr) begin
      req_q <= pmc_pkg::mode_t'(i_mode_sel);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fsel_q <= pmc_pkg::FLASH_SEL_RESET;
      keep_q <= pmc_pkg::SRAM_KEEP_RESET;
    end else begin
      if (i_flash_sel_wr) begin
        fsel_q <= i_flash_sel;
      end
      if (i_mode_wr) begin
        keep_q <= i_sram_keep;
      end
    end
  end

  // Switcher off from reset until software asks
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sw_q <= 1'b0;
    end else if (i_switcher_wr) begin
      sw_q <= i_switcher_en;
    end
  end

  // Rail level treated as a static strap, sampled each cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      lv_q <= 1'b0;
    end else begin
      lv_q <= i_low_volt_detect;
    end
  end

  // Only a wait-for-interrupt moves out of run; no self-initiated sleep
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_RUN;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (i_wfi && !i_irq) begin
            unique case (req_q)
              pmc_pkg::MODE_SLEEP: state_q <= ST_SLEEP;
              pmc_pkg::MODE_DEEP: state_q <= ST_DEEP;
              pmc_pkg::MODE_RETAIN: begin
                // Debugger keeps clocks alive, fall back to deep sleep
                state_q <= dbg_ok ? ST_DEEP : ST_RETAIN;
              end
              pmc_pkg::MODE_RUN: state_q <= ST_RUN;
            endcase
          end
        end
        ST_SLEEP: begin
          if (i_irq) begin
            state_q <= ST_RUN;
          end
        end
        ST_DEEP, ST_RETAIN: begin
          if (i_irq) begin
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (fl.good) begin
            state_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  assign flash_req = (state_q == ST_RUN) || (state_q == ST_SLEEP) || (state_q == ST_WAKE);
  assign fl.request = flash_req;
  assign fl.bank_sel = (state_q == ST_WAKE) ? fsel_q : {pmc_pkg::FLASH_BANKS{1'b1}};

  // Outputs registered from state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_mode <= 2'h0;
      o_cpu_clk_en <= 1'b1;
      o_cpu_stall <= 1'b0;
      o_slow_clk_sel <= 1'b0;
      o_fast_osc_en <= 1'b1;
      o_digital_pwr <= 1'b1;
      o_sram_pwr <= {pmc_pkg::SRAM_BANKS{1'b1}};
      o_retention_pwr <= 1'b1;
      o_ldo_en <= {pmc_pkg::REG_COUNT{1'b1}};
    end else begin
      o_cpu_clk_en <= (state_q == ST_RUN);
      o_cpu_stall <= (state_q == ST_WAKE);
      o_slow_clk_sel <= (state_q == ST_RETAIN);
      o_fast_osc_en <= (state_q != ST_RETAIN);
      o_digital_pwr <= (state_q != ST_RETAIN);
      o_sram_pwr <= (state_q == ST_RETAIN) ? keep_q : {pmc_pkg::SRAM_BANKS{1'b1}};
      o_retention_pwr <= 1'b1;
      // LDO 0 digital, 1 flash, 2 fast osc, 3 analog
      o_ldo_en <= {state_q != ST_RETAIN, state_q != ST_RETAIN, flash_req,
                   state_q != ST_RETAIN};
      unique case (state_q)
        ST_SLEEP: o_mode <= 2'(pmc_pkg::MODE_SLEEP);
        ST_DEEP: o_mode <= 2'(pmc_pkg::MODE_DEEP);
        ST_RETAIN: o_mode <= 2'(pmc_pkg::MODE_RETAIN);
        default: o_mode <= 2'(pmc_pkg::MODE_RUN);
      endcase
    end
  end

  assign o_flash_pwr = fl.bank_pwr;
  assign o_prereg_en = !lv_q;
  assign o_switcher_en = sw_q && !lv_q;
  assign o_one_volt_mode = lv_q;

  property p_wake_stall;
    @(posedge i_clk) disable iff (i_reset)
    (state_q == ST_WAKE) |=> o_cpu_stall && !o_cpu_clk_en;
  endproperty
  a_wake_stall: assert property (p_wake_stall) else $error("no stall in wake");

  property p_no_self_sleep;
    @(posedge i_clk) disable iff (i_reset)
    (state_q == ST_RUN && !i_wfi) |=> state_q == ST_RUN;
  endproperty
  a_no_self_sleep: assert property (p_no_self_sleep) else $error("left run without wfi");

  property p_dbg_block;
    @(posedge i_clk) disable iff (i_reset)
    dbg_ok && state_q == ST_RUN |=> state_q != ST_RETAIN;
  endproperty
  a_dbg_block: assert property (p_dbg_block) else $error("retention entered with debugger");

  property p_sleep_wake;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_SLEEP && i_irq |=> ##1 o_cpu_clk_en;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake failed");

  property p_deep_flash_off;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_DEEP ##1 state_q == ST_DEEP |-> o_flash_pwr == '0;
  endproperty
  a_deep_flash_off: assert property (p_deep_flash_off) else $error("flash on in deep");

  property p_retain_clk;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_RETAIN |=> !o_fast_osc_en && o_slow_clk_sel && !o_cpu_clk_en;
  endproperty
  a_retain_clk: assert property (p_retain_clk) else $error("retention clocking wrong");

  property p_sram_on;
    @(posedge i_clk) disable iff (i_reset)
    state_q != ST_RETAIN |=> o_sram_pwr == {pmc_pkg::SRAM_BANKS{1'b1}} && o_fast_osc_en;
  endproperty
  a_sram_on: assert property (p_sram_on) else $error("sram off outside retention");

  property p_low_volt;
    @(posedge i_clk) disable iff (i_reset)
    i_low_volt_detect |=> !o_prereg_en && o_one_volt_mode && !o_switcher_en;
  endproperty
  a_low_volt: assert property (p_low_volt) else $error("1 V mode not applied");

  // Wake from deep sleep or retention runs in steps
  sequence s_low_irq;
    (state_q == ST_DEEP || state_q == ST_RETAIN) && i_irq;
  endsequence

  sequence s_flash_up;
    state_q == ST_WAKE && fl.good;
  endsequence

  sequence s_wake_wait;
    state_q == ST_WAKE && !fl.good;
  endsequence

  property p_low_wake;
    @(posedge i_clk) disable iff (i_reset)
    s_low_irq |=> state_q == ST_WAKE ##1 o_cpu_stall && !o_cpu_clk_en;
  endproperty
  a_low_wake: assert property (p_low_wake) else $error("no wake from low mode");

  property p_stall_hold;
    @(posedge i_clk) disable iff (i_reset)
    s_wake_wait |=> state_q == ST_WAKE;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("wake left before flash good");

  property p_flash_up_run;
    @(posedge i_clk) disable iff (i_reset)
    s_flash_up |=> state_q == ST_RUN ##1 o_cpu_clk_en && !o_cpu_stall;
  endproperty
  a_flash_up_run: assert property (p_flash_up_run) else $error("no resume after flash");

  property p_wake_banks;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_WAKE |=> o_flash_pwr == $past(fsel_q);
  endproperty
  a_wake_banks: assert property (p_wake_banks) else $error("wrong flash banks on wake");

  property p_wake_digital;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_WAKE |=> o_digital_pwr && o_fast_osc_en && !o_slow_clk_sel;
  endproperty
  a_wake_digital: assert property (p_wake_digital) else $error("digital off in wake");

  property p_run_on;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_RUN |=> o_cpu_clk_en && !o_cpu_stall && o_fast_osc_en && o_digital_pwr;
  endproperty
  a_run_on: assert property (p_run_on) else $error("run domains wrong");

  property p_sleep_gate;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_SLEEP |=> !o_cpu_clk_en && o_flash_pwr == {pmc_pkg::FLASH_BANKS{1'b1}};
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep domains wrong");

  property p_deep_power;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_DEEP |=> !o_cpu_clk_en && o_digital_pwr && o_ldo_en == 4'hD;
  endproperty
  a_deep_power: assert property (p_deep_power) else $error("deep power wrong");

  property p_retain_power;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_RETAIN |=> !o_digital_pwr && o_retention_pwr
      && o_sram_pwr == $past(keep_q) && o_ldo_en == '0;
  endproperty
  a_retain_power: assert property (p_retain_power) else $error("retention power wrong");

  property p_mode_latch;
    @(posedge i_clk) disable iff (i_reset)
    i_mode_wr |=> 2'(req_q) == $past(i_mode_sel);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode request not latched");

  property p_mode_code;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_RETAIN |=> o_mode == 2'(pmc_pkg::MODE_RETAIN);
  endproperty
  a_mode_code: assert property (p_mode_code) else $error("mode code wrong");

  property p_switch_reset;
    @(posedge i_clk) disable iff (i_reset)
    !sw_q && !i_switcher_wr |=> !o_switcher_en;
  endproperty
  a_switch_reset: assert property (p_switch_reset) else $error("switcher on by itself");

  property p_prereg;
    @(posedge i_clk) disable iff (i_reset)
    !i_low_volt_detect |=> o_prereg_en && !o_one_volt_mode;
  endproperty
  a_prereg: assert property (p_prereg) else $error("pre-regulator not selected");

  property p_sleep_stay;
    @(posedge i_clk) disable iff (i_reset)
    (state_q == ST_SLEEP || state_q == ST_DEEP || state_q == ST_RETAIN) && !i_irq
      |=> state_q == $past(state_q);
  endproperty
  a_sleep_stay: assert property (p_sleep_stay) else $error("low mode left without irq");

  property p_irq_blocks_wfi;
    @(posedge i_clk) disable iff (i_reset)
    state_q == ST_RUN && i_irq |=> state_q == ST_RUN;
  endproperty
  a_irq_blocks_wfi: assert property (p_irq_blocks_wfi) else $error("slept with irq");
endmodule
`default_nettype wire

// ### tb/flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_pwr,
  input wire logic [7:0] i_delay,
  output logic o_ready
);
  logic [7:0] cnt_q;
  // Ready drops at once with power; a long delay exposes a missing stall
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= 8'h00;
      o_ready <= 1'b0;
    end else if (i_pwr == 2'h0) begin
      cnt_q <= 8'h00;
      o_ready <= 1'b0;
    end else if (cnt_q < i_delay) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      o_ready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_power_mode_controller.sv
`timescale 1ns/1ns
`default_nettype none
module tb_power_mode_controller;
  localparam int GC = 3;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [1:0] mode_sel = 2'h0, keep = 2'h0, fsel = 2'h0, o_mode, o_flash_pwr, o_sram_pwr;
  logic mode_wr = 0, fsel_wr = 0, sw_en = 0, sw_wr = 0, wfi = 0, irq = 0, lv = 0, dbg = 0;
  logic dbg_pin = 1'b1;
  logic [7:0] dom;
  logic clk_en, stall, slow, fast, dig, ret, prereg, sw_out, one_v, ready;
  logic [3:0] ldo;
  logic [7:0] delay = 8'h01;
  int miscompares = 0, check_count = 0, seed = 89151, n;
  always #25 i_clk = ~i_clk;
  power_mode_controller #(.GOOD_CYC(GC)) power_mode_controller_i (.i_clk(i_clk),
    .i_reset(i_reset), .i_mode_sel(mode_sel), .i_mode_wr(mode_wr), .i_sram_keep(keep),
    .i_flash_sel(fsel), .i_flash_sel_wr(fsel_wr), .i_switcher_en(sw_en),
    .i_switcher_wr(sw_wr), .i_wfi(wfi), .i_irq(irq), .i_flash_ready(ready),
    .i_low_volt_detect(lv), .i_debug_enable_pin(dbg_pin), .i_debug_attached(dbg),
    .o_mode(o_mode), .o_cpu_clk_en(clk_en), .o_cpu_stall(stall), .o_slow_clk_sel(slow),
    .o_fast_osc_en(fast), .o_digital_pwr(dig), .o_flash_pwr(o_flash_pwr),
    .o_sram_pwr(o_sram_pwr), .o_retention_pwr(ret), .o_prereg_en(prereg),
    .o_switcher_en(sw_out), .o_one_volt_mode(one_v), .o_ldo_en(ldo));
  flash_model flash_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_pwr(o_flash_pwr),
    .i_delay(delay), .o_ready(ready));
  assign dom = {clk_en, slow, fast, dig, o_flash_pwr, o_sram_pwr};
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Model: {clk_en, slow, fast, digital, flash[1:0], sram[1:0]}
  function automatic logic [7:0] exp_vec(input int m, input logic [1:0] k);
    case (m)
      0: return 8'hBF;
      1: return 8'h3F;
      2: return 8'h33;
      default: return {6'h10, k};
    endcase
  endfunction
  task automatic wrap_up();
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Enter a low mode by software, then wake by interrupt
  task automatic go_low(input int m, input logic d);
    int em;
    int s;
    @(posedge i_clk);
    em = (m == 3 && d && dbg_pin) ? 2 : m;
    mode_sel <= m[1:0];
    keep <= 2'($random(seed));
    mode_wr <= 1'b1;
    dbg <= d;
    @(posedge i_clk);
    mode_wr <= 1'b0;
    wfi <= 1'b1;
    @(posedge i_clk);
    wfi <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk("mode", {6'h00, o_mode}, em[7:0]);
    chk("domains", dom, exp_vec(em, keep));
    chk("ldo", {4'h0, ldo}, (em == 3) ? 8'h00 : ((em == 2) ? 8'h0D : 8'h0F));
    chk("ret_pwr", {7'h00, ret}, 8'h01);
    @(posedge i_clk);
    irq <= 1'b1;
    n = 0;
    s = 0;
    while (clk_en !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
      if (stall === 1'b1) begin
        s++;
      end
      if (em > 1 && stall === 1'b1 && ready !== 1'b1) begin
        chk("wake_flash", {6'h00, o_flash_pwr}, {6'h00, fsel});
      end
    end
    chk("woke_mode", {6'h00, o_mode}, 8'h00);
    chk("woke_clk", {7'h00, clk_en}, 8'h01);
    chk("woke_dom", dom, exp_vec(0, 2'h3));
    chk("woke_ldo", {4'h0, ldo}, 8'h0F);
    chk("woke_stall", {7'h00, stall}, 8'h00);
    if (em > 1) begin
      chk("fetch_ready", {7'h00, ready}, 8'h01);
      chk("wake_long", {7'h00, s > GC}, 8'h01);
    end else begin
      chk("sleep_stall", {7'h00, s == 0}, 8'h01);
    end
    @(posedge i_clk);
    irq <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (2) @(negedge i_clk);
    chk("reset_run", dom, exp_vec(0, 2'h3));
    chk("reset_reg", {6'h00, prereg, sw_out}, 8'h02);
    @(posedge i_clk);
    // Zero banks would leave wake waiting for a flash that never powers
    fsel <= 2'h1 + 2'({$random(seed)} % 3);
    fsel_wr <= 1'b1;
    @(posedge i_clk);
    fsel_wr <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      delay <= (i % 2) ? 8'h14 : 8'h01;
      go_low(1 + (i % 3), i == 5);
    end
    // Pin low means no live debugger, so retention is allowed
    dbg_pin <= 1'b0;
    go_low(3, 1'b1);
    // Wait-for-interrupt while an interrupt is pending is ignored
    @(posedge i_clk);
    mode_sel <= 2'h1;
    mode_wr <= 1'b1;
    irq <= 1'b1;
    @(posedge i_clk);
    mode_wr <= 1'b0;
    wfi <= 1'b1;
    @(posedge i_clk);
    wfi <= 1'b0;
    irq <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk("wfi_irq", {6'h00, clk_en, o_mode == 2'h0}, 8'h03);
    // Switcher enabled only while the main supply is high
    @(posedge i_clk);
    sw_en <= 1'b1;
    sw_wr <= 1'b1;
    @(posedge i_clk);
    sw_wr <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk("switcher", {5'h00, prereg, sw_out, one_v}, 8'h06);
    @(posedge i_clk);
    lv <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk("one_volt", {5'h00, prereg, sw_out, one_v}, 8'h01);
    // Mid-run reset must drop the switcher again
    @(posedge i_clk);
    lv <= 1'b0;
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (2) @(negedge i_clk);
    chk("reset_again", dom, exp_vec(0, 2'h3));
    chk("reset_reg2", {2'h0, stall, o_mode, prereg, sw_out, one_v}, 8'h04);
    wrap_up();
  end
  // Whole run needs under two hundred cycles; this bound only catches hangs
  initial begin
    #(50 * 20000);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
